// ===== shared/mac_tx_consts.svh
// constants of the transmit control register block
//
// Behaviour
// (R1) csr registers 32 bits, little endian
// (R2) reads accept any byte-enable pattern
// (R3) only byte/word/dword writes; others target-aborted
// (R4) all other addresses reserved, read zero; 12'h100 here returns a status word
// (R5) burst field bits 29-24, zero unlimited
// (R6) bit 18 enables udp checksum generation
// (R7) bit 17 enables tcp checksum generation
// (R8) bit 16 enables ip header checksum generation
// (R9) software should enable crc with checksums
// (R10) full duplex flow control sends pause
// (R11) half duplex flow control applies backpressure
// (R12) bit 2 pads frames below 64 bytes
// (R13) padding forces crc append on
// (R14) bit 1 appends crc to frames
// (R15) bit 0 enables and runs transmit dma
// (R16) stop only after current frame ends
// (R17) stop command acts only while running
// (R18) software writes control register near last
// (R19) reserved bits read zero, writes ignored
`ifndef MAC_TX_CONSTS_SVH
`define MAC_TX_CONSTS_SVH

`define CSR_ADDR_W        12
`define TX_CTRL_OFFSET    12'h000
`define TX_STATUS_OFFSET  12'h100
`define TX_CTRL_RESET     32'h0000_0000
`define TX_CTRL_WMASK     32'h3f07_0207
`define TX_BURST_LSB      24
`define TX_BURST_MSB      29
`define TX_UDP_BIT        18
`define TX_TCP_BIT        17
`define TX_IP_BIT         16
`define TX_FLOW_BIT       9
`define TX_PAD_BIT        2
`define TX_FCS_BIT        1
`define TX_RUN_BIT        0
`define TX_MIN_FRAME      7'h40

`endif

// ===== shared/mac_tx_pkg.sv
// types shared by both ends of the transmit control register link
`default_nettype none
package mac_tx_pkg;

    typedef enum logic [1:0] {
        TX_STOPPED  = 2'b00,
        TX_RUNNING  = 2'b01,
        TX_STOPPING = 2'b10
    } tx_state_t;

    typedef struct packed {
        logic [5:0] burst;
        logic       udpSum;
        logic       tcpSum;
        logic       ipSum;
        logic       flowCtrl;
        logic       padShort;
        logic       appendFcs;
        logic       dmaRun;
    } tx_ctrl_t;

    typedef struct packed {
        tx_ctrl_t    ctrl;
        tx_state_t   txState;
        logic [31:0] rdata;
        logic        abort;
        logic        fcsOut;
        logic        pauseArmed;
        logic        pausePulse;
        logic        backpressure;
    } dev_state_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [3:0]  beN;
        logic        wr;
        logic        rd;
        logic        rdPend;
        logic [31:0] rdata;
        logic        rdValid;
        logic        abortSeen;
        logic        refused;
    } host_state_t;

    // active-low enables: one byte, an aligned half word or the whole word
    function automatic logic be_legal(input logic [3:0] beN);
        case (beN)
            4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3, 4'h0: be_legal = 1'b1;
            default:                                   be_legal = 1'b0;
        endcase
    endfunction

endpackage
`default_nettype wire

// ===== shared/mac_csr_if.sv
// register access link between the bus master and the transmit control block
`default_nettype none
interface mac_csr_if;
    logic [11:0] csrAddr;
    logic [31:0] csrWdata;
    logic [3:0]  pciByteEnableN;
    logic        csrWrite;
    logic        csrRead;
    logic [31:0] csrRdata;
    logic        csrAbort;

    modport dev (
        input  csrAddr, csrWdata, pciByteEnableN, csrWrite, csrRead,
        output csrRdata, csrAbort
    );
    modport host (
        output csrAddr, csrWdata, pciByteEnableN, csrWrite, csrRead,
        input  csrRdata, csrAbort
    );
endinterface
`default_nettype wire

// ===== hw/mac_tx_dev.sv
// transmit dma control register and run/stop control, device end
//
// The strobed register port was chosen for this implementation.
`include "mac_tx_consts.svh"
`default_nettype none
module mac_tx_dev (
    input  wire logic  sys_clk,            // 25 MHz clock
    input  wire logic  resetn,             // async reset, active low
    mac_csr_if.dev     csr,                // register access link
    input  wire logic  fullDuplex,         // link is in full duplex
    input  wire logic  rxBufHigh,          // receive buffer near overflow
    input  wire logic  frameActive,        // a frame is being transmitted
    output logic [5:0] txBurstWordLimit,   // words per dma burst, 0 = no limit
    output logic       txUdpSumGen,        // insert udp checksum
    output logic       txTcpSumGen,        // insert tcp checksum
    output logic       txIpSumGen,         // insert ip header checksum
    output logic       txFlowCtrlEn,       // flow control bit as written
    output logic       txPadShortEn,       // pad frames shorter than minimum
    output logic [6:0] txMinFrameBytes,    // padding target length
    output logic       txAppendFcs,        // append crc, forced by padding
    output logic       txDmaRun,           // engine may start new frames
    output logic       txStopped,          // transmit process stopped
    output logic       pauseReq,           // one-cycle request to send pause
    output logic       backpressure        // half duplex jam level
);

    // ==================================================================
    // state registers
    mac_tx_pkg::dev_state_t stateQ;
    mac_tx_pkg::dev_state_t stateD;

    logic [31:0] ctrlWord;
    logic [31:0] statusWord;
    logic [31:0] laneMask;
    logic [31:0] newCtrl;
    logic        ctrlHit;
    logic        statusHit;
    logic        writeOk;

    // ==================================================================
    // byte lane decode, little endian
    // enable bit i, active low, opens bits 8i+7:8i
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign laneMask[lane*8 +: 8] = {8{~csr.pciByteEnableN[lane]}}; // R1
        end
    endgenerate

    assign ctrlHit   = (csr.csrAddr == `TX_CTRL_OFFSET);
    assign statusHit = (csr.csrAddr == `TX_STATUS_OFFSET);
    // legality gates the whole write, so an aborted access touches no lane
    assign writeOk   = csr.csrWrite && mac_tx_pkg::be_legal(csr.pciByteEnableN); // R3

    always_comb begin
        ctrlWord = '0;
        ctrlWord[`TX_BURST_MSB:`TX_BURST_LSB] = stateQ.ctrl.burst; // R5
        ctrlWord[`TX_UDP_BIT]  = stateQ.ctrl.udpSum;
        ctrlWord[`TX_TCP_BIT]  = stateQ.ctrl.tcpSum;
        ctrlWord[`TX_IP_BIT]   = stateQ.ctrl.ipSum;
        ctrlWord[`TX_FLOW_BIT] = stateQ.ctrl.flowCtrl;
        ctrlWord[`TX_PAD_BIT]  = stateQ.ctrl.padShort;
        ctrlWord[`TX_FCS_BIT]  = stateQ.ctrl.appendFcs;
        ctrlWord[`TX_RUN_BIT]  = stateQ.ctrl.dmaRun;
    end

    // own read-only status word; writes to its offset fall on no register
    // and are dropped like any other unmapped access
    always_comb begin
        statusWord = '0;
        statusWord[1:0] = stateQ.txState;
        statusWord[2]   = stateQ.backpressure;
        statusWord[3]   = ~stateQ.pauseArmed;
    end

    // only enabled lanes of writable bits change; reserved bits stay zero
    assign newCtrl = (ctrlWord & ~(laneMask & `TX_CTRL_WMASK))
                   | (csr.csrWdata & laneMask & `TX_CTRL_WMASK); // R19

    // ==================================================================
    // next state
    always_comb begin
        stateD = stateQ;
        // one-cycle answers fall back to zero unless set below
        stateD.abort      = 1'b0;
        stateD.pausePulse = 1'b0;
        stateD.rdata      = '0;

        // reads take any byte-enable pattern and always return the whole word
        if (csr.csrRead) begin // R2
            if (ctrlHit) begin
                stateD.rdata = ctrlWord;
            end else if (statusHit) begin
                stateD.rdata = statusWord;
            end else begin
                stateD.rdata = '0; // R4
            end
        end

        // an illegal pattern is aborted and leaves every register alone
        if (csr.csrWrite && !writeOk) begin
            stateD.abort = 1'b1; // R3
        end

        // burst size is stored unchecked: legal sizes are the driver's duty,
        // and clamping here would only hide a software fault
        if (writeOk && ctrlHit) begin
            stateD.ctrl.burst     = newCtrl[`TX_BURST_MSB:`TX_BURST_LSB]; // R5
            stateD.ctrl.udpSum    = newCtrl[`TX_UDP_BIT];  // R6
            stateD.ctrl.tcpSum    = newCtrl[`TX_TCP_BIT];  // R7
            stateD.ctrl.ipSum     = newCtrl[`TX_IP_BIT];   // R8
            stateD.ctrl.flowCtrl  = newCtrl[`TX_FLOW_BIT];
            stateD.ctrl.padShort  = newCtrl[`TX_PAD_BIT];  // R12
            stateD.ctrl.appendFcs = newCtrl[`TX_FCS_BIT];  // R14
            stateD.ctrl.dmaRun    = newCtrl[`TX_RUN_BIT];
        end

        // padding cannot work without a valid crc behind the pad
        stateD.fcsOut = stateD.ctrl.appendFcs | stateD.ctrl.padShort; // R13

        // run/stop sequencing follows the enable bit
        // the stop is taken from the written bit, so a clear while stopped
        // finds nothing to stop and the machine simply stays put
        case (stateQ.txState)
            mac_tx_pkg::TX_STOPPED: begin
                if (stateD.ctrl.dmaRun) begin
                    stateD.txState = mac_tx_pkg::TX_RUNNING; // R15
                end
            end
            mac_tx_pkg::TX_RUNNING: begin
                if (!stateD.ctrl.dmaRun) begin // R17
                    if (frameActive) begin
                        stateD.txState = mac_tx_pkg::TX_STOPPING; // R16
                    end else begin
                        stateD.txState = mac_tx_pkg::TX_STOPPED;
                    end
                end
            end
            mac_tx_pkg::TX_STOPPING: begin
                // re-enabling before the frame ends simply keeps running
                if (stateD.ctrl.dmaRun) begin
                    stateD.txState = mac_tx_pkg::TX_RUNNING;
                end else if (!frameActive) begin
                    stateD.txState = mac_tx_pkg::TX_STOPPED; // R16
                end
            end
            default: begin
                stateD.txState = mac_tx_pkg::TX_STOPPED;
            end
        endcase

        // one pause per excursion of the receive buffer above its threshold
        // a level-driven request would flood the link while the buffer stays high
        if (stateQ.ctrl.flowCtrl && fullDuplex && rxBufHigh && stateQ.pauseArmed) begin
            stateD.pausePulse = 1'b1; // R10
            stateD.pauseArmed = 1'b0;
        end else if (!rxBufHigh) begin
            stateD.pauseArmed = 1'b1;
        end

        // backpressure is a level; cleared flow control means none at all
        stateD.backpressure = stateQ.ctrl.flowCtrl && !fullDuplex && rxBufHigh; // R11
    end

    // ==================================================================
    // registers
    // reset image of the control word, unpacked field by field below
    localparam logic [31:0] CtrlReset = `TX_CTRL_RESET;

    // one register for the whole struct keeps every field under the same reset
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stateQ                <= '0;
            stateQ.ctrl.burst     <= CtrlReset[`TX_BURST_MSB:`TX_BURST_LSB];
            stateQ.ctrl.udpSum    <= CtrlReset[`TX_UDP_BIT];
            stateQ.ctrl.tcpSum    <= CtrlReset[`TX_TCP_BIT];
            stateQ.ctrl.ipSum     <= CtrlReset[`TX_IP_BIT];
            stateQ.ctrl.flowCtrl  <= CtrlReset[`TX_FLOW_BIT];
            stateQ.ctrl.padShort  <= CtrlReset[`TX_PAD_BIT];
            stateQ.ctrl.appendFcs <= CtrlReset[`TX_FCS_BIT];
            stateQ.ctrl.dmaRun    <= CtrlReset[`TX_RUN_BIT];
            stateQ.fcsOut         <= CtrlReset[`TX_FCS_BIT] | CtrlReset[`TX_PAD_BIT];
            stateQ.txState        <= mac_tx_pkg::TX_STOPPED;
            stateQ.pauseArmed     <= 1'b1;
        end else begin
            stateQ <= stateD;
        end
    end

    // ==================================================================
    // outputs
    // frames are the datapath's; this block only hands it enables
    assign csr.csrRdata      = stateQ.rdata;
    assign csr.csrAbort      = stateQ.abort;
    assign txBurstWordLimit  = stateQ.ctrl.burst;
    assign txUdpSumGen       = stateQ.ctrl.udpSum;  // R6
    assign txTcpSumGen       = stateQ.ctrl.tcpSum;  // R7
    assign txIpSumGen        = stateQ.ctrl.ipSum;   // R8
    assign txFlowCtrlEn      = stateQ.ctrl.flowCtrl;
    assign txPadShortEn      = stateQ.ctrl.padShort; // R12
    assign txMinFrameBytes   = `TX_MIN_FRAME;        // R12
    assign txAppendFcs       = stateQ.fcsOut;        // R14
    assign txDmaRun          = (stateQ.txState == mac_tx_pkg::TX_RUNNING); // R15
    assign txStopped         = (stateQ.txState == mac_tx_pkg::TX_STOPPED);
    assign pauseReq          = stateQ.pausePulse;    // R10
    assign backpressure      = stateQ.backpressure;  // R11

endmodule
`default_nettype wire

// ===== hw/mac_tx_host.sv
// bus master end that drives register accesses onto the link
`include "mac_tx_consts.svh"
`default_nettype none
module mac_tx_host (
    input  wire logic        sys_clk,   // 25 MHz clock
    input  wire logic        resetn,    // async reset, active low
    mac_csr_if.host          csr,       // register access link
    input  wire logic [11:0] cmdAddr,   // register byte offset
    input  wire logic [31:0] cmdWdata,  // write data
    input  wire logic [3:0]  cmdBeN,    // byte enables, active low
    input  wire logic        cmdWrite,  // write strobe
    input  wire logic        cmdRead,   // read strobe
    output logic      [31:0] rdData,    // captured read data
    output logic             rdValid,   // one-cycle pulse with rdData
    output logic             abortSeen, // sticky: device aborted a write
    output logic             refused    // sticky: illegal pattern kept off the link
);

    // ==================================================================
    // state registers
    mac_tx_pkg::host_state_t stateQ;
    mac_tx_pkg::host_state_t stateD;

    always_comb begin
        stateD = stateQ;
        stateD.wr      = 1'b0;
        stateD.rd      = 1'b0;
        stateD.rdValid = 1'b0;
        stateD.rdPend  = stateQ.rd;
        if (cmdWrite) begin
            // never put a pattern on the link that the device must abort
            if (mac_tx_pkg::be_legal(cmdBeN)) begin // R3
                stateD.wr    = 1'b1;
                stateD.addr  = cmdAddr;
                stateD.wdata = cmdWdata;
                stateD.beN   = cmdBeN;
            end else begin
                stateD.refused = 1'b1;
            end
        end else if (cmdRead) begin
            stateD.rd   = 1'b1;
            stateD.addr = cmdAddr;
            stateD.beN  = cmdBeN;
        end
        if (stateQ.rdPend) begin
            stateD.rdata   = csr.csrRdata;
            stateD.rdValid = 1'b1;
        end
        if (csr.csrAbort) begin
            stateD.abortSeen = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stateQ     <= '0;
            stateQ.beN <= 4'hf;
        end else begin
            stateQ <= stateD;
        end
    end

    assign csr.csrAddr        = stateQ.addr;
    assign csr.csrWdata       = stateQ.wdata;
    assign csr.pciByteEnableN = stateQ.beN;
    assign csr.csrWrite       = stateQ.wr;
    assign csr.csrRead        = stateQ.rd;
    assign rdData             = stateQ.rdata;
    assign rdValid            = stateQ.rdValid;
    assign abortSeen          = stateQ.abortSeen;
    assign refused            = stateQ.refused;

endmodule
`default_nettype wire

// ===== tb/mac_tx_assertions.sv
// link checker for the transmit control register accesses
`include "mac_tx_consts.svh"
`default_nettype none
module mac_tx_assertions (
    input wire logic        sys_clk,        // clock
    input wire logic        resetn,         // reset, active low
    input wire logic [11:0] csrAddr,        // byte offset
    input wire logic [31:0] csrWdata,       // write data
    input wire logic [3:0]  pciByteEnableN, // enables, active low
    input wire logic        csrWrite,       // write strobe
    input wire logic        csrRead,        // read strobe
    input wire logic [31:0] csrRdata,       // read data
    input wire logic        csrAbort        // target abort
);
    // ==========================================
    // helpers
    logic legalBe;
    logic unmapped;
    assign legalBe  = pciByteEnableN inside {4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3, 4'h0};
    assign unmapped = csrAddr != `TX_CTRL_OFFSET && csrAddr != `TX_STATUS_OFFSET;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence fullWrRd;
        csrWrite && csrAddr == `TX_CTRL_OFFSET && pciByteEnableN == 4'h0 ##1 csrRead && csrAddr == `TX_CTRL_OFFSET;
    endsequence
    sequence laneWrRd;
        csrWrite && csrAddr == `TX_CTRL_OFFSET && pciByteEnableN == 4'hb ##1 csrRead && csrAddr == `TX_CTRL_OFFSET;
    endsequence
    // ==========================================
    // assertions
    host_legal_a: assert property (csrWrite |-> legalBe)
        else $error("illegal byte enables reached the link");
    one_strobe_a: assert property (!(csrWrite && csrRead))
        else $error("read and write strobes together");
    no_abort_a: assert property (!(csrWrite && !legalBe) |=> !csrAbort)
        else $error("abort without an illegal write");
    rdata_idle_a: assert property (!csrRead |=> csrRdata == 32'h0)
        else $error("read data outside the answer cycle");
    unmapped_zero_a: assert property (csrRead && unmapped |=> csrRdata == 32'h0)
        else $error("unmapped offset read nonzero");
    ctrl_reserved_a: assert property (csrRead && csrAddr == `TX_CTRL_OFFSET |=>
        (csrRdata & ~`TX_CTRL_WMASK) == 32'h0)
        else $error("reserved control bits read nonzero");
    word_readback_a: assert property (fullWrRd |=> csrRdata == ($past(csrWdata, 2) & `TX_CTRL_WMASK))
        else $error("control word readback wrong");
    byte_lane_a: assert property (laneWrRd |=> ((csrRdata ^ $past(csrWdata, 2)) & 32'h0007_0000) == 32'h0)
        else $error("byte lane two readback wrong");
endmodule
`default_nettype wire

// ===== tb/mac_tx_dma_control_csr_tb.sv
// self-checking bench for the transmit control register link, both ends
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module mac_tx_dma_control_csr_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // signals and instances
    logic        sys_clk;
    logic        resetn;
    logic [11:0] cmdAddr;
    logic [31:0] cmdWdata;
    logic [3:0]  cmdBeN;
    logic        cmdWrite;
    logic        cmdRead;
    logic        fullDuplex;
    logic        rxBufHigh;
    logic        frameActive;
    logic [31:0] rdData;
    logic        rdValid;
    logic        abortSeen;
    logic        refused;
    logic [5:0]  txBurstWordLimit;
    logic        txUdpSumGen;
    logic        txTcpSumGen;
    logic        txIpSumGen;
    logic        txFlowCtrlEn;
    logic        txPadShortEn;
    logic [6:0]  txMinFrameBytes;
    logic        txAppendFcs;
    logic        txDmaRun;
    logic        txStopped;
    logic        pauseReq;
    logic        backpressure;
    logic [12:0] outs;
    logic [5:0]  bv;
    int          n_errors;
    int          n_compared;
    int          pulses;
    assign outs = {txBurstWordLimit, txUdpSumGen, txTcpSumGen, txIpSumGen, txFlowCtrlEn, txPadShortEn,
                   txAppendFcs, txDmaRun};
    mac_csr_if link();
    mac_tx_host mac_tx_host_i (.sys_clk, .resetn, .csr(link), .cmdAddr, .cmdWdata, .cmdBeN, .cmdWrite,
                               .cmdRead, .rdData, .rdValid, .abortSeen, .refused);
    mac_tx_dev mac_tx_dev_i (.sys_clk, .resetn, .csr(link), .fullDuplex, .rxBufHigh, .frameActive,
                             .txBurstWordLimit, .txUdpSumGen, .txTcpSumGen, .txIpSumGen, .txFlowCtrlEn,
                             .txPadShortEn, .txMinFrameBytes, .txAppendFcs, .txDmaRun, .txStopped,
                             .pauseReq, .backpressure);
    mac_tx_assertions mac_tx_assertions_i (.sys_clk, .resetn, .csrAddr(link.csrAddr),
                                           .csrWdata(link.csrWdata), .pciByteEnableN(link.pciByteEnableN),
                                           .csrWrite(link.csrWrite), .csrRead(link.csrRead),
                                           .csrRdata(link.csrRdata), .csrAbort(link.csrAbort));
    // ==========================================
    // tasks
    task automatic wrap_up();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // write and/or read; with both, the read follows the write with no gap on the link
    task automatic acc(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] b, input logic [31:0] e);
        int i;
        @(posedge sys_clk);
        cmdAddr  <= a;
        cmdWdata <= d;
        cmdBeN   <= b;
        cmdWrite <= w;
        cmdRead  <= !w;
        @(posedge sys_clk);
        cmdWrite <= 1'b0;
        cmdRead  <= w & r;
        if (w & r) begin
            @(posedge sys_clk);
            cmdRead <= 1'b0;
        end
        i = 0;
        while (r && rdValid !== 1'b1 && i < 8) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        if (i == 8) begin
            n_errors++;
            $display("BAD rdValid exp 1 got 0");
            wrap_up();
        end else if (r) `CHK("rdData", e, rdData)
        else begin
            repeat (3) @(posedge sys_clk);
            #1;
        end
    endtask
    task automatic cnt(input int n);
        pulses = 0;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            pulses += (pauseReq === 1'b1);
        end
    endtask
    // ==========================================
    // clock and sequence
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        n_errors    = 0;
        n_compared  = 0;
        resetn      = 1'b0;
        cmdAddr     = 12'h000;
        cmdWdata    = 32'h0;
        cmdBeN      = 4'hf;
        cmdWrite    = 1'b0;
        cmdRead     = 1'b0;
        fullDuplex  = 1'b0;
        rxBufHigh   = 1'b0;
        frameActive = 1'b0;
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        #1;
        `CHK("state", 2'b01, {txDmaRun, txStopped})
        `CHK("minLen", 7'h40, txMinFrameBytes)
        acc(1'b0, 1'b1, 12'h000, 32'h0, 4'hf, 32'h0);
        acc(1'b1, 1'b1, 12'h000, 32'hffff_ffff, 4'h0, 32'h3f07_0207);
        `CHK("ctrl", 13'h1fff, outs)
        @(posedge sys_clk);
        rxBufHigh <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK("backpressure", 1'b1, backpressure)
        @(posedge sys_clk);
        fullDuplex <= 1'b1;
        cnt(6);
        `CHK("pauses", 1, pulses)
        `CHK("backpressure", 1'b0, backpressure)
        acc(1'b0, 1'b1, 12'h100, 32'h0, 4'h0, 32'h0000_0009);
        @(posedge sys_clk);
        fullDuplex  <= 1'b0;
        frameActive <= 1'b1;
        acc(1'b1, 1'b0, 12'h000, 32'h0000_0004, 4'h0, 32'h0);
        `CHK("stopping", 2'b00, {txDmaRun, txStopped})
        `CHK("ctrl", 13'h0006, outs)
        `CHK("backpressure", 1'b0, backpressure)
        acc(1'b0, 1'b1, 12'h100, 32'h0, 4'hf, 32'h0000_000a);
        @(posedge sys_clk);
        frameActive <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK("stopped", 2'b01, {txDmaRun, txStopped})
        @(posedge sys_clk);
        frameActive <= 1'b1;
        acc(1'b1, 1'b0, 12'h000, 32'h0000_0002, 4'h0, 32'h0);
        `CHK("ignored", 2'b01, {txDmaRun, txStopped})
        `CHK("ctrl", 13'h0002, outs)
        acc(1'b1, 1'b1, 12'h000, 32'h0007_0000, 4'hb, 32'h0007_0002);
        acc(1'b1, 1'b1, 12'h000, 32'hffff_ffff, 4'h5, 32'h0007_0002);
        `CHK("flags", 2'b10, {refused, abortSeen})
        acc(1'b1, 1'b1, 12'h000, 32'h0000_0200, 4'hc, 32'h0007_0200);
        acc(1'b1, 1'b1, 12'h004, 32'hffff_ffff, 4'h0, 32'h0);
        acc(1'b0, 1'b1, 12'h000, 32'h0, 4'h5, 32'h0007_0200);
        for (int k = 0; k < 7; k++) begin
            bv = (k == 0) ? 6'h00 : 6'(1 << (k - 1));
            acc(1'b1, 1'b1, 12'h000, {2'b00, bv, 24'h0}, 4'h0, {2'b00, bv, 24'h0});
            `CHK("burst", bv, txBurstWordLimit)
        end
        wrap_up();
    end
endmodule
`default_nettype wire
